// ==== hw/rpm_monitor.sv ====
// Summary of operation
// - 40 points; change without detector, 5 s
// - failure delay may lie within 5..10 s
// - detector active 60 s raises alarm
// - no monitor capture after detector failure
// - detector-failure code until next step press
// - monitor lamp blinks after detector failure
// - failure ORs changed-point pattern into record
// - repeat toggles stored once, record accumulates
// - records erased only by clear request, or a trip slot by a new trip
// - first failure closes alarm until clear
// - after trip scan points 10 ms
// - trip and monitor records kept separate
// - five trip events, oldest overwritten
// - trip held shows trip-held code
// - trip preempts any mode, then monitor
// - clear erases both records, both contacts
`timescale 1ns/1ps
`default_nettype none

module rpm_monitor #(
	parameter int unsigned P_TICK_CYCLES  = rpm_pkg::TICK_CYCLES,
	parameter int unsigned P_PERSIST_MS   = rpm_pkg::PERSIST_MS,
	parameter int unsigned P_DET_STUCK_MS = rpm_pkg::DET_STUCK_MS
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_srst,
	input  wire logic [39:0] i_points,
	input  wire logic        i_fault_detector_signal,
	input  wire logic        i_trip,
	input  wire logic        i_clear_local,
	input  wire logic        i_clear_remote,
	input  wire logic        i_display_step_button,
	input  wire logic        i_data_select,
	output logic             o_relay_fail_alarm,
	output logic             o_relay_fail_alarm_aux,
	output logic             o_det_fail_alarm,
	output logic             o_monitor_data_lamp,
	output logic             o_trip_data_lamp,
	output logic [3:0]       o_disp_upper,
	output logic [3:0]       o_disp_lower
);

	localparam int unsigned NP = rpm_pkg::NUM_POINTS;
	localparam int unsigned NE = rpm_pkg::TRIP_EVENTS;

	// first point number (1..40) at bit index >= from, else 0
	function automatic logic [5:0] next_point(input logic [39:0] vec,
		input logic [5:0] from);
		logic [5:0] r;
		r = 6'h00;
		for (int i = NP - 1; i >= 0; i--) begin
			if (vec[i] && (i >= int'(from)))
				r = 6'(i + 1);
		end
		return r;
	endfunction

	// ring slot holding the k-th newest event (k = 1 newest)
	function automatic logic [2:0] slot_of(input logic [2:0] newest,
		input logic [2:0] k);
		return 3'((int'(newest) + NE + 1 - int'(k)) % NE);
	endfunction

	logic clear_req;
	assign clear_req = i_clear_local | i_clear_remote;

	// common tick and lamp blink
	logic [14:0] tick_cnt_q, tick_cnt_d;
	logic        tick_q, tick_d;
	logic [9:0]  blink_cnt_q, blink_cnt_d;
	logic        blink_q, blink_d;

	always_comb begin
		tick_cnt_d  = tick_cnt_q + 15'h0001;
		tick_d      = 1'b0;
		blink_cnt_d = blink_cnt_q;
		blink_d     = blink_q;
		if (tick_cnt_q == 15'(P_TICK_CYCLES - 1)) begin
			tick_cnt_d = 15'h0000;
			tick_d     = 1'b1;
		end
		if (tick_q) begin
			blink_cnt_d = blink_cnt_q + 10'h001;
			if (blink_cnt_q == 10'(rpm_pkg::BLINK_HALF_MS - 1)) begin
				blink_cnt_d = 10'h000;
				blink_d     = ~blink_q;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			tick_cnt_q  <= 15'h0000;
			tick_q      <= 1'b0;
			blink_cnt_q <= 10'h000;
			blink_q     <= 1'b0;
		end else begin
			tick_cnt_q  <= tick_cnt_d;
			tick_q      <= tick_d;
			blink_cnt_q <= blink_cnt_d;
			blink_q     <= blink_d;
		end
	end

	// relay-system failure and detector supervision
	logic [39:0] ref_q, ref_d;
	logic [16:0] persist_q, persist_d;
	logic [16:0] det_cnt_q, det_cnt_d;
	logic        det_fail_q, det_fail_d;
	logic [39:0] mon_rec_q, mon_rec_d;
	logic        alarm_q, alarm_d;
	logic [39:0] diff;

	always_comb begin
		diff        = i_points ^ ref_q;
		ref_d       = ref_q;
		persist_d   = persist_q;
		det_cnt_d   = det_cnt_q;
		det_fail_d  = det_fail_q;
		mon_rec_d   = mon_rec_q;
		alarm_d     = alarm_q;
		if (clear_req) begin
			mon_rec_d = rpm_pkg::REC_RESET;
			alarm_d   = 1'b0;
		end
		// detector stuck active is itself a failure
		if (!i_fault_detector_signal) begin
			det_cnt_d = 17'h00000;
		end else if (tick_q && !det_fail_q) begin
			det_cnt_d = det_cnt_q + 17'h00001;
			if (det_cnt_d == 17'(P_DET_STUCK_MS))
				det_fail_d = 1'b1;
		end
		// a fault explains any change, so follow the points then
		if (i_fault_detector_signal || det_fail_q) begin
			ref_d     = i_points;
			persist_d = 17'h00000;
		end else if (diff == 40'h00_0000_0000) begin
			persist_d = 17'h00000;
		end else if (tick_q) begin
			persist_d = persist_q + 17'h00001;
			// fixed 5 s sits inside the allowed 5..10 s band
			if (persist_d == 17'(P_PERSIST_MS)) begin
				mon_rec_d = mon_rec_d | diff;
				alarm_d   = 1'b1;
				ref_d     = i_points;
				persist_d = 17'h00000;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			ref_q       <= rpm_pkg::REC_RESET;
			persist_q   <= 17'h00000;
			det_cnt_q   <= 17'h00000;
			det_fail_q  <= 1'b0;
			mon_rec_q   <= rpm_pkg::REC_RESET;
			alarm_q     <= 1'b0;
		end else begin
			ref_q       <= ref_d;
			persist_q   <= persist_d;
			det_cnt_q   <= det_cnt_d;
			det_fail_q  <= det_fail_d;
			mon_rec_q   <= mon_rec_d;
			alarm_q     <= alarm_d;
		end
	end

	// trip capture ring, independent of the monitor record
	rpm_pkg::rpm_mode_t mode_q, mode_d;
	logic        trip_prev_q, trip_prev_d;
	logic [39:0] snap_q, snap_d;
	logic [3:0]  scan_q, scan_d;
	logic [39:0] ring_q [NE];
	logic [39:0] ring_d [NE];
	logic [2:0]  newest_q, newest_d;
	logic [2:0]  count_q, count_d;
	logic        trip_rise;

	always_comb begin
		trip_rise   = i_trip & ~trip_prev_q;
		trip_prev_d = i_trip;
		mode_d      = mode_q;
		snap_d      = snap_q;
		scan_d      = scan_q;
		ring_d      = ring_q;
		newest_d    = newest_q;
		count_d     = count_q;
		if (clear_req) begin
			count_d = 3'h0;
			mode_d  = rpm_pkg::RPM_MODE_MONITOR;
			for (int i = 0; i < NE; i++)
				ring_d[i] = rpm_pkg::REC_RESET;
		end else if (mode_q == rpm_pkg::RPM_MODE_TRIP_SCAN) begin
			ring_d[newest_q] = ring_q[newest_q] | (i_points ^ snap_q);
			if (tick_q) begin
				scan_d = scan_q + 4'h1;
				if (scan_d == 4'(rpm_pkg::TRIP_SCAN_MS))
					mode_d = rpm_pkg::RPM_MODE_MONITOR;
			end
		end
		// a new trip wins over everything, even a clear
		if (trip_rise) begin
			newest_d = (newest_q == 3'(NE - 1)) ? 3'h0
				: newest_q + 3'h1;
			ring_d[newest_d] = rpm_pkg::REC_RESET;
			if (count_d != 3'(NE))
				count_d = count_d + 3'h1;
			snap_d = i_points;
			scan_d = 4'h0;
			mode_d = rpm_pkg::RPM_MODE_TRIP_SCAN;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			mode_q      <= rpm_pkg::RPM_MODE_MONITOR;
			trip_prev_q <= 1'b0;
			snap_q      <= rpm_pkg::REC_RESET;
			scan_q      <= 4'h0;
			ring_q      <= '{default: rpm_pkg::REC_RESET};
			newest_q    <= 3'h0;
			count_q     <= 3'h0;
		end else begin
			mode_q      <= mode_d;
			trip_prev_q <= trip_prev_d;
			snap_q      <= snap_d;
			scan_q      <= scan_d;
			ring_q      <= ring_d;
			newest_q    <= newest_d;
			count_q     <= count_d;
		end
	end

	// front-panel stepping, display and lamps
	logic       step_prev_q, step_prev_d;
	logic       sel_prev_q, sel_prev_d;
	logic [2:0] evt_q, evt_d;
	logic [5:0] pt_q, pt_d;
	logic       det_show_q, det_show_d;
	logic [3:0] upper_d, lower_d;
	logic       mon_lamp_d, trip_lamp_d;
	logic       step;
	logic [5:0] nxt;

	always_comb begin
		step        = i_display_step_button & ~step_prev_q;
		step_prev_d = i_display_step_button;
		sel_prev_d  = i_data_select;
		evt_d       = evt_q;
		pt_d        = pt_q;
		det_show_d  = det_show_q;
		nxt         = 6'h00;
		if (i_data_select != sel_prev_q || clear_req) begin
			evt_d = 3'h0;
			pt_d  = 6'h00;
		end else if (step && !i_trip) begin
			det_show_d = 1'b0;
			if (!i_data_select) begin
				pt_d = next_point(mon_rec_q, pt_q);
			end else if (evt_q == 3'h0) begin
				if (count_q != 3'h0)
					evt_d = 3'h1;
			end else begin
				nxt = next_point(ring_q[slot_of(newest_q, evt_q)], pt_q);
				pt_d = nxt;
				if (nxt == 6'h00) begin
					evt_d = (evt_q < count_q) ? evt_q + 3'h1 : 3'h0;
				end
			end
		end
		if (det_fail_d && !det_fail_q)
			det_show_d = 1'b1;
		// glyph priority: clear, trip held, detector, data
		if (clear_req) begin
			upper_d = rpm_pkg::DIG_C;
			lower_d = rpm_pkg::DIG_C;
		end else if (i_trip) begin
			upper_d = rpm_pkg::DIG_F;
			lower_d = rpm_pkg::DIG_B;
		end else if (det_show_q) begin
			upper_d = rpm_pkg::DIG_F;
			lower_d = rpm_pkg::DIG_D;
		end else if (pt_q != 6'h00) begin
			upper_d = 4'(pt_q / 6'd10);
			lower_d = 4'(pt_q % 6'd10);
		end else if (evt_q != 3'h0) begin
			upper_d = rpm_pkg::DIG_E;
			lower_d = {1'b0, evt_q};
		end else begin
			upper_d = rpm_pkg::DIG_ZERO;
			lower_d = rpm_pkg::DIG_ZERO;
		end
		mon_lamp_d  = det_fail_q ? blink_q
			: (mon_rec_q != rpm_pkg::REC_RESET);
		trip_lamp_d = (count_q != 3'h0);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			step_prev_q            <= 1'b0;
			sel_prev_q             <= 1'b0;
			evt_q                  <= 3'h0;
			pt_q                   <= 6'h00;
			det_show_q             <= 1'b0;
			o_disp_upper           <= rpm_pkg::DIG_ZERO;
			o_disp_lower           <= rpm_pkg::DIG_ZERO;
			o_monitor_data_lamp    <= 1'b0;
			o_trip_data_lamp       <= 1'b0;
			o_relay_fail_alarm     <= 1'b0;
			o_relay_fail_alarm_aux <= 1'b0;
			o_det_fail_alarm       <= 1'b0;
		end else begin
			step_prev_q            <= step_prev_d;
			sel_prev_q             <= sel_prev_d;
			evt_q                  <= evt_d;
			pt_q                   <= pt_d;
			det_show_q             <= det_show_d;
			o_disp_upper           <= upper_d;
			o_disp_lower           <= lower_d;
			o_monitor_data_lamp    <= mon_lamp_d;
			o_trip_data_lamp       <= trip_lamp_d;
			o_relay_fail_alarm     <= alarm_q;
			o_relay_fail_alarm_aux <= alarm_q;
			o_det_fail_alarm       <= det_fail_q;
		end
	end

endmodule

`default_nettype wire

// ==== hw/rpm_pkg.sv ====
package rpm_pkg;

	// system clock and the common millisecond tick
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned TICK_PERIOD_US = 1000;
	localparam int unsigned TICK_CYCLES   =
		CLK_HZ / 1_000_000 * TICK_PERIOD_US;

	// monitored points and record depth
	localparam int unsigned NUM_POINTS  = 40;
	localparam int unsigned TRIP_EVENTS = 5;

	// timing, in seconds and in milliseconds of the common tick
	localparam int unsigned PERSIST_MIN_S  = 5;
	localparam int unsigned PERSIST_MAX_S  = 10;
	localparam int unsigned PERSIST_MS     = PERSIST_MIN_S * 1000;
	localparam int unsigned DET_STUCK_S    = 60;
	localparam int unsigned DET_STUCK_MS   = DET_STUCK_S * 1000;
	localparam int unsigned TRIP_SCAN_MS   = 10;
	localparam int unsigned BLINK_HALF_MS  = 500;

	// counter widths
	localparam int unsigned TICK_W = 15;
	localparam int unsigned MS_W   = 17;
	localparam int unsigned PT_W   = 6;
	localparam int unsigned EVT_W  = 3;

	// two-digit display glyphs
	localparam logic [3:0] DIG_ZERO = 4'h0;
	localparam logic [3:0] DIG_B    = 4'hb;
	localparam logic [3:0] DIG_C    = 4'hc;
	localparam logic [3:0] DIG_D    = 4'hd;
	localparam logic [3:0] DIG_E    = 4'he;
	localparam logic [3:0] DIG_F    = 4'hf;

	// reset values
	localparam logic [39:0] REC_RESET = 40'h00_0000_0000;

	typedef enum logic {
		RPM_MODE_MONITOR,
		RPM_MODE_TRIP_SCAN
	} rpm_mode_t;

endpackage

// ==== testbench/rpm_monitor_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module rpm_monitor_checker (
	input wire logic       i_sys_clk,
	input wire logic       i_srst,
	input wire logic       i_fault_detector_signal,
	input wire logic       i_trip,
	input wire logic       i_clear_local,
	input wire logic       i_clear_remote,
	input wire logic       o_relay_fail_alarm,
	input wire logic       o_relay_fail_alarm_aux,
	input wire logic       o_det_fail_alarm,
	input wire logic       o_trip_data_lamp,
	input wire logic [3:0] o_disp_upper,
	input wire logic [3:0] o_disp_lower
);
	logic clr;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	assign clr = i_clear_local | i_clear_remote;
	sequence s_clr3;
		clr [*3];
	endsequence
	sequence s_trip_rise;
		$rose(i_trip) && !clr ##1 !clr;
	endsequence
	property p_aux;
		o_relay_fail_alarm_aux == o_relay_fail_alarm;
	endproperty
	a_aux: assert property (p_aux) else $error("contacts differ");
	// record clears reach the contact two flops later
	property p_hold;
		o_relay_fail_alarm && !$past(clr) && !$past(clr, 2)
			|=> o_relay_fail_alarm;
	endproperty
	a_hold: assert property (p_hold) else $error("alarm dropped");
	property p_clr;
		s_clr3 |-> ##[1:2] !o_relay_fail_alarm;
	endproperty
	a_clr: assert property (p_clr) else $error("alarm kept");
	property p_clr_disp;
		clr |=> o_disp_upper == rpm_pkg::DIG_C
			&& o_disp_lower == rpm_pkg::DIG_C;
	endproperty
	a_clr_disp: assert property (p_clr_disp) else $error("no c/c");
	property p_trip_disp;
		i_trip && !clr |=> o_disp_upper == rpm_pkg::DIG_F
			&& o_disp_lower == rpm_pkg::DIG_B;
	endproperty
	a_trip_disp: assert property (p_trip_disp) else $error("no f/b");
	property p_trip_lamp;
		s_trip_rise |-> ##1 o_trip_data_lamp;
	endproperty
	a_trip_lamp: assert property (p_trip_lamp) else $error("no lamp");
	property p_det_keep;
		o_det_fail_alarm |=> o_det_fail_alarm;
	endproperty
	a_det_keep: assert property (p_det_keep) else $error("lost");
	property p_det_cause;
		$rose(o_det_fail_alarm) |-> $past(i_fault_detector_signal, 2);
	endproperty
	a_det_cause: assert property (p_det_cause) else $error("cause");
	property p_no_cap;
		o_det_fail_alarm && $past(o_det_fail_alarm) && !o_relay_fail_alarm
			|=> !o_relay_fail_alarm;
	endproperty
	a_no_cap: assert property (p_no_cap) else $error("captured");
endmodule
bind rpm_monitor rpm_monitor_checker i_chk (
	.i_sys_clk              (i_sys_clk),
	.i_srst                 (i_srst),
	.i_fault_detector_signal(i_fault_detector_signal),
	.i_trip                 (i_trip),
	.i_clear_local          (i_clear_local),
	.i_clear_remote         (i_clear_remote),
	.o_relay_fail_alarm     (o_relay_fail_alarm),
	.o_relay_fail_alarm_aux (o_relay_fail_alarm_aux),
	.o_det_fail_alarm       (o_det_fail_alarm),
	.o_trip_data_lamp       (o_trip_data_lamp),
	.o_disp_upper           (o_disp_upper),
	.o_disp_lower           (o_disp_lower)
);
`default_nettype wire

// ==== testbench/rpm_scheme_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rpm_scheme_model (
	input  wire logic        i_sys_clk,
	output logic      [39:0] o_points,
	output logic             o_fault_detector_signal,
	output logic             o_trip
);
	initial begin
		o_points = 40'h00_0000_0000;
		o_fault_detector_signal = 1'b0;
		o_trip = 1'b0;
	end
	// moves land on the falling edge, clear of sampling
	task automatic flip(input int n);
		@(negedge i_sys_clk);
		o_points[n] = ~o_points[n];
	endtask
	task automatic set_det(input logic v);
		@(negedge i_sys_clk);
		o_fault_detector_signal = v;
	endtask
	task automatic set_trip(input logic v);
		@(negedge i_sys_clk);
		o_trip = v;
	endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin \
	checks++; \
	if ((a) !== (e)) begin \
		mismatches++; \
		$display("CHECK FAILED %s exp %0h got %0h", n, e, a); \
	end \
end
`define WAIT(c, n) begin \
	for (w = 0; w < (n) && (c) !== 1'b1; w++) cyc(1); \
	if ((c) !== 1'b1) begin \
		mismatches++; \
		conclude(); \
	end \
end
module testbench;
	localparam int TK = 4;
	localparam int PMS = 20;
	localparam int FMS = 50;
	logic        clk, srst, clr_l, clr_r, step, dsel, det, trip;
	logic        alm, alm_x, det_alm, mlamp, tlamp;
	logic [39:0] pts;
	logic [3:0]  du, dl;
	int          checks, mismatches, w;
	rpm_monitor #(
		.P_TICK_CYCLES (TK),
		.P_PERSIST_MS  (PMS),
		.P_DET_STUCK_MS(FMS)
	) i_dut (
		.i_sys_clk              (clk),
		.i_srst                 (srst),
		.i_points               (pts),
		.i_fault_detector_signal(det),
		.i_trip                 (trip),
		.i_clear_local          (clr_l),
		.i_clear_remote         (clr_r),
		.i_display_step_button  (step),
		.i_data_select          (dsel),
		.o_relay_fail_alarm     (alm),
		.o_relay_fail_alarm_aux (alm_x),
		.o_det_fail_alarm       (det_alm),
		.o_monitor_data_lamp    (mlamp),
		.o_trip_data_lamp       (tlamp),
		.o_disp_upper           (du),
		.o_disp_lower           (dl)
	);
	rpm_scheme_model i_mdl (
		.i_sys_clk              (clk),
		.o_points               (pts),
		.o_fault_detector_signal(det),
		.o_trip                 (trip)
	);
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic press();
		step = 1'b1;
		cyc(3);
		step = 1'b0;
		cyc(1);
	endtask
	task automatic t_relay();
		i_mdl.flip(2);
		cyc(TK * PMS - 10);
		i_mdl.flip(2);
		cyc(TK * PMS + 20);
		`CHK("short change", 1'b0, alm)
		i_mdl.flip(2);
		`WAIT(alm, 200)
		`CHK("delay", 1'b1, w >= TK * PMS - 4 && w <= TK * PMS + 6)
		`CHK("aux", 1'b1, alm_x)
		`CHK("lamp", 1'b1, mlamp)
		i_mdl.flip(2);
		cyc(TK * PMS + 20);
		press();
		`CHK("point", 8'h03, {du, dl})
		press();
		`CHK("once", 8'h00, {du, dl})
		`CHK("held", 1'b1, alm)
		clr_r = 1'b1;
		cyc(1);
		`CHK("clear code", 8'hcc, {du, dl})
		cyc(2);
		clr_r = 1'b0;
		cyc(4);
		`CHK("alarm off", 1'b0, alm_x)
		`CHK("lamp off", 1'b0, mlamp)
		$display("relay test done");
	endtask
	task automatic t_trip();
		int k;
		i_mdl.set_det(1'b1);
		i_mdl.set_trip(1'b1);
		cyc(4);
		i_mdl.flip(19);
		cyc(2);
		`CHK("held code", 8'hfb, {du, dl})
		cyc(60);
		// point 31 moves after the scan window closed
		i_mdl.flip(30);
		i_mdl.set_trip(1'b0);
		i_mdl.set_det(1'b0);
		cyc(3);
		`CHK("trip lamp", 1'b1, tlamp)
		dsel = 1'b1;
		cyc(3);
		press();
		`CHK("event", 8'he1, {du, dl})
		press();
		`CHK("trip point", 8'h20, {du, dl})
		press();
		`CHK("late point", 8'h00, {du, dl})
		for (k = 0; k < 5; k++) begin
			i_mdl.set_trip(1'b1);
			i_mdl.set_trip(1'b0);
		end
		cyc(60);
		dsel = 1'b0;
		cyc(3);
		dsel = 1'b1;
		cyc(3);
		for (k = 1; k < 7; k++) begin
			press();
			`CHK("ring", k < 6 ? {4'he, 4'(k)} : 8'h00, {du, dl})
		end
		`CHK("no alarm", 1'b0, alm)
		i_mdl.flip(7);
		`WAIT(alm, TK * PMS + 20)
		`CHK("back to monitor", 1'b1, alm)
		dsel = 1'b0;
		clr_l = 1'b1;
		cyc(3);
		clr_l = 1'b0;
		cyc(4);
		`CHK("trip lamp off", 1'b0, tlamp)
		$display("trip test done");
	endtask
	task automatic t_det();
		i_mdl.set_det(1'b1);
		`WAIT(det_alm, TK * FMS + 40)
		`CHK("stuck time", 1'b1, w >= TK * FMS - 4)
		cyc(1);
		`CHK("detector code", 8'hfd, {du, dl})
		i_mdl.set_det(1'b0);
		`WAIT(mlamp, 2100)
		`WAIT(mlamp === 1'b0, 2100)
		press();
		`CHK("code gone", 8'h00, {du, dl})
		i_mdl.flip(5);
		cyc(TK * PMS + 20);
		`CHK("no capture", 1'b0, alm)
		`CHK("stays gone", 8'h00, {du, dl})
		$display("detector test done");
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		srst = 1'b1;
		clr_l = 1'b0;
		clr_r = 1'b0;
		step = 1'b0;
		dsel = 1'b0;
		checks = 0;
		mismatches = 0;
		cyc(8);
		srst = 1'b0;
		cyc(2);
		t_relay();
		t_trip();
		t_det();
		conclude();
	end
endmodule
`default_nettype wire
